// ===== fap_flash_guard.sv
// Access guard, bank organisation and error-code checking for a dual-bank flash.
// Notes on behaviour
// - Two banks; one bank reads while the other erases or programs.
// - Each bank holds 256 erasable pages of 2 Kbyte.
// - Three readout levels; level 0 restricts no requester.
// - Level 1 denies main memory access with debug, RAM boot or loader boot.
// - Level 2 locks out debug and non-user boot; the level cannot drop.
// - Level 1 restricted context blocks backup registers; level 2 locks options.
// - Going from level 1 to level 0 wipes backup registers and block SRAM.
// - Program and erase blocked inside two write-protect page areas per bank.
// - Execute-only areas serve instruction fetches only; everything else is refused.
// - One execute-only area per bank, bounded on 64-bit words.
// - An option bit chooses whether execute-only areas are wiped on level regress.
// - Every word carries a code correcting one and detecting two bit errors.
// - An error-code failure records the failing address for software.
module fap_flash_guard (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic [1:0] opt_level_in,
  input wire logic opt_exec_erase_in,
  input wire logic [4*fap_pkg::FAP_PAGE_W-1:0] opt_wp_start_in,
  input wire logic [4*fap_pkg::FAP_PAGE_W-1:0] opt_wp_end_in,
  input wire logic [2*fap_pkg::FAP_WADDR_W-1:0] opt_xo_start_in,
  input wire logic [2*fap_pkg::FAP_WADDR_W-1:0] opt_xo_end_in,
  input wire logic debug_connected_in,
  input wire logic [1:0] boot_sel_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_master_in,
  input wire logic [1:0] req_op_in,
  input wire logic [fap_pkg::FAP_WADDR_W:0] req_addr_in,
  input wire logic [fap_pkg::FAP_DATA_W-1:0] req_wdata_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic rsp_valid_out,
  output logic rsp_err_out,
  output logic [fap_pkg::FAP_DATA_W-1:0] rsp_rdata_out,
  output logic [31:0] reg_rdata_out,
  output logic ready_out,
  output logic [1:0] level_out,
  output logic debug_disable_out,
  output logic boot_force_user_out,
  output logic backup_deny_out,
  output logic optbyte_write_deny_out,
  output logic backup_erase_out,
  output logic sram_block_erase_out,
  output logic [1:0] bank_busy_out
);
  import fap_pkg::*;

  typedef struct packed {
    fap_state_t st;
    logic ready;
    logic [1:0] level;
    logic exec_erase;
    logic [4*FAP_PAGE_W-1:0] wp_start;
    logic [4*FAP_PAGE_W-1:0] wp_end;
    logic [2*FAP_WADDR_W-1:0] xo_start;
    logic [2*FAP_WADDR_W-1:0] xo_end;
    logic p1_valid;
    logic p1_read;
    logic p1_denied;
    logic [FAP_WADDR_W:0] p1_addr;
    logic rsp_valid;
    logic rsp_err;
    logic [FAP_DATA_W-1:0] rsp_rdata;
    logic [31:0] reg_rdata;
    logic ecc_corr;
    logic ecc_dbl;
    logic chg_refused;
    logic [FAP_WADDR_W:0] ecc_addr;
    logic eng_busy;
    logic eng_bank;
    logic eng_regress1;
    logic [FAP_WADDR_W-1:0] eng_addr;
    logic [FAP_WADDR_W-1:0] eng_end;
    logic dbg_dis;
    logic boot_force;
    logic bkp_deny;
    logic opt_lock;
    logic bkp_erase;
    logic sram_erase;
    logic [1:0] bank_busy;
  } fap_guard_t;

  fap_guard_t s_ff;
  fap_guard_t nxt_s;
  logic [FAP_BANKS-1:0] mem_we;
  logic [FAP_BANKS-1:0] mem_re;
  logic [FAP_BANKS-1:0][FAP_WADDR_W-1:0] mem_addr;
  logic [FAP_BANKS-1:0][FAP_CW_W-1:0] mem_wdata;
  logic [FAP_BANKS-1:0][FAP_CW_W-1:0] mem_rdata;
  logic [FAP_DATA_W-1:0] dec_data;
  logic dec_single, dec_double;
  logic restricted, in_wp, in_xo, req_deny, regress_now;

  function automatic logic xo_span_ok(input logic [2*FAP_WADDR_W-1:0] st,
                                      input logic [2*FAP_WADDR_W-1:0] en, input logic b);
    return st[b*FAP_WADDR_W +: FAP_WADDR_W] <= en[b*FAP_WADDR_W +: FAP_WADDR_W];
  endfunction

  // Separate banks, each with its own port, so an erase never blocks reads or programs of the other bank.
  for (genvar b = 0; b < FAP_BANKS; b++) begin : g_bank
    fap_bank_mem u_mem (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .ce_in(ce_in),
      .wr_in(mem_we[b]),
      .rd_in(mem_re[b]),
      .addr_in(mem_addr[b]),
      .wdata_in(mem_wdata[b]),
      .rdata_out(mem_rdata[b])
    );
  end

  fap_secded u_dec (
    .cw_in(mem_rdata[s_ff.p1_addr[FAP_WADDR_W]]),
    .data_out(dec_data),
    .single_out(dec_single),
    .double_out(dec_double)
  );

  always_comb begin
    logic bank;
    logic [FAP_WADDR_W-1:0] word;
    logic [FAP_PAGE_W-1:0] page;
    logic [FAP_WADDR_W-1:0] xs;
    logic [FAP_WADDR_W-1:0] xe;
    logic [1:0] idx;
    logic [1:0] lvl_new;
    logic is_read;
    bank = req_addr_in[FAP_WADDR_W];
    word = req_addr_in[FAP_WADDR_W-1:0];
    page = word[FAP_WADDR_W-1 -: FAP_PAGE_W];
    xs = s_ff.xo_start[bank*FAP_WADDR_W +: FAP_WADDR_W];
    xe = s_ff.xo_end[bank*FAP_WADDR_W +: FAP_WADDR_W];
    idx = 2'h0;
    lvl_new = reg_wdata_in[FAP_CTRL_LVL_LSB +: 2];
    is_read = req_op_in == FAP_OP_READ;
    nxt_s = s_ff;
    nxt_s.bkp_erase = 1'b0;
    nxt_s.sram_erase = 1'b0;
    nxt_s.rsp_valid = 1'b0;
    nxt_s.rsp_err = 1'b0;
    nxt_s.rsp_rdata = '0;
    nxt_s.reg_rdata = '0;
    mem_we = '0;
    mem_re = '0;
    mem_addr = '0;
    mem_wdata = '0;
    regress_now = 1'b0;

    // Level 2 has debug and non-user boot disabled, so that context cannot arise there.
    restricted = (debug_connected_in || boot_sel_in != FAP_BOOT_USER) && s_ff.level != FAP_LVL2;
    in_wp = 1'b0;
    for (int a = 0; a < 2; a++) begin
      idx = {bank, a[0]};
      if (page >= s_ff.wp_start[idx*FAP_PAGE_W +: FAP_PAGE_W] &&
          page <= s_ff.wp_end[idx*FAP_PAGE_W +: FAP_PAGE_W]) begin
        in_wp = 1'b1;
      end
    end
    // Word bounds for accesses, page overlap for erases.
    if (req_op_in == FAP_OP_ERASE) begin
      in_xo = xs <= xe && page >= xs[FAP_WADDR_W-1 -: FAP_PAGE_W] &&
              page <= xe[FAP_WADDR_W-1 -: FAP_PAGE_W];
    end else begin
      in_xo = xs <= word && word <= xe;
    end
    req_deny = s_ff.st != FAP_ST_RUN ||
               (s_ff.eng_busy && (s_ff.eng_bank == bank || req_op_in == FAP_OP_ERASE)) ||
               (s_ff.level == FAP_LVL1 && restricted) ||
               (s_ff.level == FAP_LVL2 && req_master_in == FAP_MST_DEBUG) ||
               (in_xo && !(req_master_in == FAP_MST_FETCH && is_read)) ||
               (in_wp && !is_read) ||
               req_op_in > FAP_OP_ERASE;
    // Erase engine writes the erased code word one 64-bit word per cycle.
    if (s_ff.eng_busy) begin
      mem_we[s_ff.eng_bank] = 1'b1;
      mem_addr[s_ff.eng_bank] = s_ff.eng_addr;
      mem_wdata[s_ff.eng_bank] = FAP_ERASED_CW;
      if (s_ff.eng_addr == s_ff.eng_end) begin
        nxt_s.eng_busy = 1'b0;
        nxt_s.eng_regress1 = 1'b0;
        if (s_ff.eng_regress1 && xo_span_ok(s_ff.xo_start, s_ff.xo_end, 1'b1)) begin
          nxt_s.eng_busy = 1'b1;
          nxt_s.eng_bank = 1'b1;
          nxt_s.eng_addr = s_ff.xo_start[FAP_WADDR_W +: FAP_WADDR_W];
          nxt_s.eng_end = s_ff.xo_end[FAP_WADDR_W +: FAP_WADDR_W];
        end
      end else begin
        nxt_s.eng_addr = FAP_WADDR_W'(s_ff.eng_addr + 1'b1);
      end
    end
    // A denied request touches no array port.
    if (req_valid_in && !req_deny) begin
      if (is_read) begin
        mem_re[bank] = 1'b1;
        mem_addr[bank] = word;
      end else if (req_op_in == FAP_OP_PROG) begin
        mem_we[bank] = 1'b1;
        mem_addr[bank] = word;
        mem_wdata[bank] = fap_ecc_encode(req_wdata_in);
      end else begin
        nxt_s.eng_busy = 1'b1;
        nxt_s.eng_bank = bank;
        nxt_s.eng_regress1 = 1'b0;
        nxt_s.eng_addr = {page, {(FAP_WADDR_W-FAP_PAGE_W){1'b0}}};
        nxt_s.eng_end = {page, {(FAP_WADDR_W-FAP_PAGE_W){1'b1}}};
      end
    end
    nxt_s.p1_valid = req_valid_in;
    nxt_s.p1_read = is_read;
    nxt_s.p1_denied = req_deny;
    nxt_s.p1_addr = req_addr_in;
    // Options are caught in the first cycle after reset release.
    if (s_ff.st == FAP_ST_LOAD) begin
      nxt_s.st = FAP_ST_RUN;
      nxt_s.ready = 1'b1;
      nxt_s.level = opt_level_in == 2'h3 ? FAP_LVL2 : opt_level_in;
      nxt_s.exec_erase = opt_exec_erase_in;
      nxt_s.wp_start = opt_wp_start_in;
      nxt_s.wp_end = opt_wp_end_in;
      nxt_s.xo_start = opt_xo_start_in;
      nxt_s.xo_end = opt_xo_end_in;
    end
    // Register writes: status flags clear on one, before hardware sets below.
    if (reg_wr_in && reg_addr_in == FAP_REG_STATUS) begin
      nxt_s.ecc_corr = s_ff.ecc_corr && !reg_wdata_in[FAP_STS_CORR];
      nxt_s.ecc_dbl = s_ff.ecc_dbl && !reg_wdata_in[FAP_STS_DBL];
      nxt_s.chg_refused = s_ff.chg_refused && !reg_wdata_in[FAP_STS_REFUSED];
    end else if (reg_wr_in && reg_addr_in == FAP_REG_CTRL && reg_wdata_in[FAP_CTRL_GO_BIT]) begin
      if (s_ff.st != FAP_ST_RUN || nxt_s.eng_busy || lvl_new == 2'h3 ||
          (s_ff.level == FAP_LVL2 && lvl_new != FAP_LVL2)) begin
        nxt_s.chg_refused = 1'b1;
      end else begin
        nxt_s.level = lvl_new;
        if (s_ff.level == FAP_LVL1 && lvl_new == FAP_LVL0) begin
          regress_now = 1'b1;
          nxt_s.bkp_erase = 1'b1;
          nxt_s.sram_erase = 1'b1;
          if (s_ff.exec_erase) begin
            // Bank 0 area first, then bank 1 when the engine finishes.
            nxt_s.eng_busy = 1'b1;
            nxt_s.eng_regress1 = 1'b1;
            nxt_s.eng_bank = 1'b0;
            nxt_s.eng_addr = s_ff.xo_start[0 +: FAP_WADDR_W];
            nxt_s.eng_end = s_ff.xo_end[0 +: FAP_WADDR_W];
            if (!xo_span_ok(s_ff.xo_start, s_ff.xo_end, 1'b0)) begin
              nxt_s.eng_regress1 = 1'b0;
              nxt_s.eng_bank = 1'b1;
              nxt_s.eng_addr = s_ff.xo_start[FAP_WADDR_W +: FAP_WADDR_W];
              nxt_s.eng_end = s_ff.xo_end[FAP_WADDR_W +: FAP_WADDR_W];
              nxt_s.eng_busy = xo_span_ok(s_ff.xo_start, s_ff.xo_end, 1'b1);
            end
          end
        end
      end
    end
    // Answer two cycles after the request; the read word passes the decoder.
    if (s_ff.p1_valid) begin
      nxt_s.rsp_valid = 1'b1;
      if (s_ff.p1_denied) begin
        nxt_s.rsp_err = 1'b1;
      end else if (s_ff.p1_read) begin
        nxt_s.rsp_rdata = dec_data;
        nxt_s.rsp_err = dec_double;
        if (dec_single || dec_double) begin
          nxt_s.ecc_addr = s_ff.p1_addr;
        end
        if (dec_single) begin
          nxt_s.ecc_corr = 1'b1;
        end
        if (dec_double) begin
          nxt_s.ecc_dbl = 1'b1;
        end
      end
    end
    if (reg_rd_in) begin
      if (reg_addr_in == FAP_REG_CTRL) begin
        nxt_s.reg_rdata[FAP_CTRL_LVL_LSB +: 2] = s_ff.level;
      end else if (reg_addr_in == FAP_REG_STATUS) begin
        nxt_s.reg_rdata[FAP_STS_BUSY0] = s_ff.bank_busy[0];
        nxt_s.reg_rdata[FAP_STS_BUSY1] = s_ff.bank_busy[1];
        nxt_s.reg_rdata[FAP_STS_CORR] = s_ff.ecc_corr;
        nxt_s.reg_rdata[FAP_STS_DBL] = s_ff.ecc_dbl;
        nxt_s.reg_rdata[FAP_STS_REFUSED] = s_ff.chg_refused;
        nxt_s.reg_rdata[FAP_STS_READY] = s_ff.st == FAP_ST_RUN;
      end else if (reg_addr_in == FAP_REG_ECC_ADDR) begin
        nxt_s.reg_rdata[FAP_WADDR_W:0] = s_ff.ecc_addr;
      end
    end

    nxt_s.dbg_dis = nxt_s.level == FAP_LVL2;
    nxt_s.boot_force = nxt_s.level == FAP_LVL2;
    nxt_s.opt_lock = nxt_s.level == FAP_LVL2;
    nxt_s.bkp_deny = nxt_s.level == FAP_LVL1 &&
                     (debug_connected_in || boot_sel_in != FAP_BOOT_USER);
    nxt_s.bank_busy = {nxt_s.eng_busy && nxt_s.eng_bank, nxt_s.eng_busy && !nxt_s.eng_bank};
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_ff <= '{st: FAP_ST_LOAD, default: '0};
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  assign rsp_valid_out = s_ff.rsp_valid;
  assign rsp_err_out = s_ff.rsp_err;
  assign rsp_rdata_out = s_ff.rsp_rdata;
  assign reg_rdata_out = s_ff.reg_rdata;
  assign ready_out = s_ff.ready;
  assign level_out = s_ff.level;
  assign debug_disable_out = s_ff.dbg_dis;
  assign boot_force_user_out = s_ff.boot_force;
  assign backup_deny_out = s_ff.bkp_deny;
  assign optbyte_write_deny_out = s_ff.opt_lock;
  assign backup_erase_out = s_ff.bkp_erase;
  assign sram_block_erase_out = s_ff.sram_erase;
  assign bank_busy_out = s_ff.bank_busy;

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (reset_in || !ce_in);

  sequence err_two_s;
    ##2 (rsp_valid_out && rsp_err_out);
  endsequence
  sequence wipe_pulse_s;
    ##1 (backup_erase_out && sram_block_erase_out) ##1 !backup_erase_out;
  endsequence

  level_keep_a: assert property (level_out == FAP_LVL2 |=> level_out == FAP_LVL2 &&
    debug_disable_out && boot_force_user_out) else $error("Level 2 was left or unlocked.");
  restrict_deny_a: assert property (req_valid_in && ready_out && level_out == FAP_LVL1 &&
    debug_connected_in |-> err_two_s) else $error("Restricted access was not refused.");
  wp_block_a: assert property (req_valid_in && in_wp && req_op_in == FAP_OP_PROG
    |-> err_two_s) else $error("Program inside a write-protect area was not refused.");
  xo_guard_a: assert property (req_valid_in && in_xo && req_master_in != FAP_MST_FETCH
    |-> err_two_s) else $error("Non-fetch access to execute-only area was not refused.");
  load_gate_a: assert property (req_valid_in && !ready_out |-> err_two_s)
    else $error("Access granted before options were loaded.");
  level0_open_a: assert property (req_valid_in && ready_out && level_out == FAP_LVL0 &&
    req_op_in == FAP_OP_READ && !in_xo && bank_busy_out == 2'h0 |=> !s_ff.p1_denied)
    else $error("Level 0 read was refused.");
  read_other_a: assert property (bank_busy_out[!req_addr_in[FAP_WADDR_W]] &&
    !bank_busy_out[req_addr_in[FAP_WADDR_W]] && req_valid_in && req_op_in == FAP_OP_READ &&
    !in_xo && level_out == FAP_LVL0 |=> !s_ff.p1_denied ##1 rsp_valid_out)
    else $error("Read of idle bank was blocked.");
  ecc_addr_a: assert property (s_ff.p1_valid && s_ff.p1_read && !s_ff.p1_denied &&
    dec_double |=> rsp_err_out && s_ff.ecc_dbl && s_ff.ecc_addr == $past(s_ff.p1_addr))
    else $error("Double error not reported with its address.");
  ecc_fix_a: assert property (s_ff.p1_valid && s_ff.p1_read && !s_ff.p1_denied &&
    dec_single |=> !rsp_err_out && rsp_rdata_out == $past(dec_data) && s_ff.ecc_corr)
    else $error("Single error not corrected.");
  regress_wipe_a: assert property (regress_now |-> wipe_pulse_s)
    else $error("Regress did not pulse the backup and block SRAM wipe.");
  xo_wipe_a: assert property (regress_now && s_ff.exec_erase &&
    xo_span_ok(s_ff.xo_start, s_ff.xo_end, 1'b0) |=> bank_busy_out[0])
    else $error("Execute-only area wipe did not start.");
endmodule // fap_flash_guard

// ===== fap_pkg.sv
// Shared constants, types and error-code helper for the flash access guard.
package fap_pkg;
  localparam int FAP_BANKS = 2;
  localparam int FAP_PAGES = 256;
  localparam int FAP_PAGE_BYTES = 2048;
  localparam int FAP_WORD_BYTES = 8;
  localparam int FAP_WORDS_PER_PAGE = FAP_PAGE_BYTES / FAP_WORD_BYTES;
  localparam int FAP_BANK_WORDS = FAP_PAGES * FAP_WORDS_PER_PAGE;
  localparam int FAP_WADDR_W = $clog2(FAP_BANK_WORDS);
  localparam int FAP_PAGE_W = $clog2(FAP_PAGES);
  localparam int FAP_DATA_W = 64;
  localparam int FAP_CW_W = 72;
  localparam int FAP_SYN_W = 7;
  // Readout levels; the code 3 is treated as level 2 when loaded.
  localparam logic [1:0] FAP_LVL0 = 2'h0;
  localparam logic [1:0] FAP_LVL1 = 2'h1;
  localparam logic [1:0] FAP_LVL2 = 2'h2;
  localparam logic [1:0] FAP_MST_FETCH = 2'h0;
  localparam logic [1:0] FAP_MST_DATA = 2'h1;
  localparam logic [1:0] FAP_MST_DMA = 2'h2;
  localparam logic [1:0] FAP_MST_DEBUG = 2'h3;
  localparam logic [1:0] FAP_OP_READ = 2'h0;
  localparam logic [1:0] FAP_OP_PROG = 2'h1;
  localparam logic [1:0] FAP_OP_ERASE = 2'h2;
  localparam logic [1:0] FAP_BOOT_USER = 2'h0;
  localparam logic [1:0] FAP_BOOT_RAM = 2'h1;
  localparam logic [1:0] FAP_BOOT_LOADER = 2'h2;
  localparam logic [7:0] FAP_REG_CTRL = 8'h00;
  localparam logic [7:0] FAP_REG_STATUS = 8'h04;
  localparam logic [7:0] FAP_REG_ECC_ADDR = 8'h08;
  localparam int FAP_CTRL_LVL_LSB = 0;
  localparam int FAP_CTRL_GO_BIT = 4;
  localparam int FAP_STS_BUSY0 = 0;
  localparam int FAP_STS_BUSY1 = 1;
  localparam int FAP_STS_CORR = 2;
  localparam int FAP_STS_DBL = 3;
  localparam int FAP_STS_REFUSED = 4;
  localparam int FAP_STS_READY = 5;

  typedef enum logic [1:0] {
    FAP_ST_LOAD = 2'b01,
    FAP_ST_RUN = 2'b10
  } fap_state_t;

  // Extended Hamming code: check bits at power-of-two positions, overall parity in bit 0.
  function automatic logic [FAP_CW_W-1:0] fap_ecc_encode(input logic [FAP_DATA_W-1:0] d);
    logic [FAP_CW_W-1:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p < FAP_CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < FAP_SYN_W; b++) begin
      for (int p = 1; p < FAP_CW_W; p++) begin
        if (p[b] && p != (1 << b)) begin
          c[1 << b] = c[1 << b] ^ c[p];
        end
      end
    end
    c[0] = ^c[FAP_CW_W-1:1];
    return c;
  endfunction

  localparam logic [FAP_CW_W-1:0] FAP_ERASED_CW = fap_ecc_encode(64'hFFFF_FFFF_FFFF_FFFF);
endpackage

// ===== fap_bank_mem.sv
// One flash bank array of code words with a registered read port.
module fap_bank_mem (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [fap_pkg::FAP_WADDR_W-1:0] addr_in,
  input wire logic [fap_pkg::FAP_CW_W-1:0] wdata_in,
  output logic [fap_pkg::FAP_CW_W-1:0] rdata_out
);
  import fap_pkg::*;

  typedef struct packed {
    logic [FAP_CW_W-1:0] rdata;
  } fap_mem_t;

  fap_mem_t s_ff;
  fap_mem_t nxt_s;
  logic [FAP_CW_W-1:0] array_ff [FAP_BANK_WORDS];

  always_comb begin
    nxt_s = s_ff;
    if (rd_in) begin
      nxt_s.rdata = array_ff[addr_in];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_ff <= '0;
    end else if (ce_in) begin
      s_ff <= nxt_s;
    end
  end

  // The array itself has no reset, as in a real flash macro.
  always_ff @(posedge clk_in) begin
    if (ce_in && wr_in) begin
      array_ff[addr_in] <= wdata_in;
    end
  end

  assign rdata_out = s_ff.rdata;
endmodule // fap_bank_mem

// ===== fap_secded.sv
// Combinational single-error-correct, double-error-detect decoder for one code word.
module fap_secded (
  input wire logic [fap_pkg::FAP_CW_W-1:0] cw_in,
  output logic [fap_pkg::FAP_DATA_W-1:0] data_out,
  output logic single_out,
  output logic double_out
);
  import fap_pkg::*;

  always_comb begin
    logic [FAP_SYN_W-1:0] syn;
    logic [FAP_CW_W-1:0] fixed;
    logic overall;
    int k;
    syn = '0;
    fixed = cw_in;
    overall = ^cw_in;
    k = 0;
    data_out = '0;
    for (int p = 1; p < FAP_CW_W; p++) begin
      if (cw_in[p]) begin
        syn = syn ^ FAP_SYN_W'(p);
      end
    end
    single_out = overall && (int'(syn) < FAP_CW_W);
    double_out = (!overall && syn != '0) || (overall && int'(syn) >= FAP_CW_W);
    if (single_out) begin
      fixed[syn] = ~cw_in[syn];
    end
    for (int p = 1; p < FAP_CW_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        data_out[k] = fixed[p];
        k++;
      end
    end
  end
endmodule // fap_secded

// ===== fap_req_model.sv
// Requester model for the processor, DMA and debug masters on the request port.
module fap_req_model (
  input wire logic clk_in,
  output logic req_valid_out,
  output logic [1:0] req_master_out,
  output logic [1:0] req_op_out,
  output logic [fap_pkg::FAP_WADDR_W:0] req_addr_out,
  output logic [fap_pkg::FAP_DATA_W-1:0] req_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import fap_pkg::*;
  initial begin
    req_valid_out = 1'b0;
    req_master_out = FAP_MST_FETCH;
    req_op_out = FAP_OP_READ;
    req_addr_out = '0;
    req_wdata_out = '0;
  end
  // Address and write data are inverted once released, so the guard cannot lean on stale values.
  task automatic issue(input logic [1:0] mst, input logic [1:0] op,
                       input logic [FAP_WADDR_W:0] addr, input logic [FAP_DATA_W-1:0] wd);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_master_out <= mst;
    req_op_out <= op;
    req_addr_out <= addr;
    req_wdata_out <= wd;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_addr_out <= ~addr;
    req_wdata_out <= ~wd;
  endtask
endmodule // fap_req_model

// ===== tb_top.sv
// Self-checking bench for the flash access guard.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fap_pkg::*;
  localparam logic [64:0] ERR = {1'b1, 64'h0};
  localparam logic [64:0] OK = {1'b0, 64'h0};
  localparam logic [64:0] ONES = {1'b0, 64'hFFFF_FFFF_FFFF_FFFF};
  localparam logic [16:0] A = 17'h00020;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic ce_in = 1'b1;
  logic [1:0] opt_level_in = FAP_LVL0;
  logic opt_exec_erase_in = 1'b1;
  // Bank 0 area 0 guards pages 5 to 6; the other areas sit on page 255, never used here.
  logic [31:0] opt_wp_start_in = 32'hFFFF_FF05;
  logic [31:0] opt_wp_end_in = 32'hFFFF_FF06;
  // Bank 0 execute-only words 0x0300 to 0x0303; bank 1 has none since start is above end.
  logic [31:0] opt_xo_start_in = 32'hFFFF_0300;
  logic [31:0] opt_xo_end_in = 32'h0000_0303;
  logic debug_connected_in = 1'b0;
  logic [1:0] boot_sel_in = FAP_BOOT_USER;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic req_valid, rsp_valid_out, rsp_err_out, ready_out, debug_disable_out, rd_d;
  logic boot_force_user_out, backup_deny_out, optbyte_write_deny_out;
  logic backup_erase_out, sram_block_erase_out;
  logic [1:0] req_master, req_op, level_out, bank_busy_out, n_bk, n_sr;
  logic [16:0] req_addr;
  logic [63:0] req_wdata, rsp_rdata_out, d1;
  logic [31:0] reg_rdata_out;
  logic [64:0] rsp_q[$];
  logic [31:0] reg_q[$];
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  fap_req_model u_req (.clk_in(clk_in), .req_valid_out(req_valid), .req_master_out(req_master),
    .req_op_out(req_op), .req_addr_out(req_addr), .req_wdata_out(req_wdata));
  fap_flash_guard u_dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
    .opt_level_in(opt_level_in), .opt_exec_erase_in(opt_exec_erase_in),
    .opt_wp_start_in(opt_wp_start_in), .opt_wp_end_in(opt_wp_end_in),
    .opt_xo_start_in(opt_xo_start_in), .opt_xo_end_in(opt_xo_end_in),
    .debug_connected_in(debug_connected_in), .boot_sel_in(boot_sel_in),
    .req_valid_in(req_valid), .req_master_in(req_master), .req_op_in(req_op),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .rsp_valid_out(rsp_valid_out), .rsp_err_out(rsp_err_out), .rsp_rdata_out(rsp_rdata_out),
    .reg_rdata_out(reg_rdata_out), .ready_out(ready_out), .level_out(level_out),
    .debug_disable_out(debug_disable_out), .boot_force_user_out(boot_force_user_out),
    .backup_deny_out(backup_deny_out), .optbyte_write_deny_out(optbyte_write_deny_out),
    .backup_erase_out(backup_erase_out), .sram_block_erase_out(sram_block_erase_out),
    .bank_busy_out(bank_busy_out));

  always #12.5 clk_in = ~clk_in;

  task automatic compare(input logic [64:0] got, input logic [64:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (rsp_q.size() != 0 || reg_q.size() != 0) begin
      fail_count++;
      $display("[ERR] %0t answers missing", $time);
    end
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Responses and register reads are matched in order against the oldest note.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (rsp_valid_out === 1'b1)
      compare({rsp_err_out, rsp_rdata_out}, rsp_q.size() ? rsp_q.pop_front() : {65{1'bx}}, "rsp");
    if (rd_d === 1'b1)
      compare(65'(reg_rdata_out), reg_q.size() ? 65'(reg_q.pop_front()) : {65{1'bx}}, "reg");
    rd_d <= reg_rd_in;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic req(input logic [1:0] mst, input logic [1:0] op, input logic [16:0] addr,
                     input logic [63:0] wd, input logic [64:0] exp);
    rsp_q.push_back(exp);
    u_req.issue(mst, op, addr, wd);
  endtask

  task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    if (!wr) reg_q.push_back(d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= wr;
    reg_rd_in <= !wr;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask

  task automatic drain();
    repeat (4) @(posedge clk_in);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk_in);
    while (bank_busy_out !== 2'b00 && n < 2000) begin
      @(posedge clk_in);
      n++;
    end
    compare(bank_busy_out, 2'b00, "busy");
  endtask

  initial begin
    void'($urandom(32'h50A5));
    repeat (12) @(posedge clk_in);
    compare(ready_out, 1'b0, "ready in reset");
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    compare({ready_out, level_out}, {1'b1, FAP_LVL0}, "loaded");
    reg_acc(1'b0, FAP_REG_STATUS, 32'h20);
    reg_acc(1'b0, 8'h0C, 32'h0);
    d1 = {$urandom, $urandom};
    req(FAP_MST_DATA, FAP_OP_PROG, A, d1, OK);
    for (int m = 0; m < 4; m++) req(2'(m), FAP_OP_READ, A, 64'h0, {1'b0, d1});
    req(FAP_MST_DATA, FAP_OP_PROG, 17'h00510, d1, ERR);
    req(FAP_MST_DATA, FAP_OP_ERASE, 17'h00600, 64'h0, ERR);
    for (int m = 1; m < 4; m++) req(2'(m), FAP_OP_READ, 17'h00303, 64'h0, ERR);
    req(FAP_MST_DATA, FAP_OP_PROG, 17'h00300, d1, ERR);
    req(FAP_MST_DATA, FAP_OP_ERASE, 17'h003C0, 64'h0, ERR);
    req(FAP_MST_DATA, FAP_OP_ERASE, 17'h10200, 64'h0, OK);
    req(FAP_MST_DMA, FAP_OP_READ, A, 64'h0, {1'b0, d1});
    compare(bank_busy_out, 2'b10, "busy bank1");
    wait_idle();
    req(FAP_MST_DATA, FAP_OP_READ, 17'h10200, 64'h0, ONES);
    req(FAP_MST_DATA, FAP_OP_READ, 17'h102FF, 64'h0, ONES);
    reg_acc(1'b1, FAP_REG_CTRL, 32'h11);
    drain();
    compare(level_out, FAP_LVL1, "level1");
    req(FAP_MST_FETCH, FAP_OP_READ, A, 64'h0, {1'b0, d1});
    for (int i = 0; i < 3; i++) begin
      debug_connected_in <= (i == 0);
      boot_sel_in <= 2'(i);
      req(FAP_MST_FETCH, FAP_OP_READ, A, 64'h0, ERR);
      req(FAP_MST_DATA, FAP_OP_PROG, A, ~d1, ERR);
      drain();
      compare(backup_deny_out, 1'b1, "backup deny");
    end
    debug_connected_in <= 1'b0;
    boot_sel_in <= FAP_BOOT_USER;
    req(FAP_MST_DATA, FAP_OP_READ, A, 64'h0, {1'b0, d1});
    drain();
    compare(backup_deny_out, 1'b0, "backup allowed");
    reg_acc(1'b1, FAP_REG_CTRL, 32'h10);
    n_bk = 2'b00;
    n_sr = 2'b00;
    repeat (3) begin
      @(posedge clk_in);
      n_bk = n_bk + backup_erase_out;
      n_sr = n_sr + sram_block_erase_out;
    end
    compare({n_bk, n_sr}, 4'b0101, "wipe pulses");
    wait_idle();
    req(FAP_MST_FETCH, FAP_OP_READ, 17'h00301, 64'h0, ONES);
    reg_acc(1'b1, FAP_REG_CTRL, 32'h12);
    drain();
    compare({debug_disable_out, boot_force_user_out, optbyte_write_deny_out}, 3'b111, "l2");
    req(FAP_MST_DEBUG, FAP_OP_READ, A, 64'h0, ERR);
    req(FAP_MST_FETCH, FAP_OP_READ, A, 64'h0, {1'b0, d1});
    req(FAP_MST_FETCH, 2'h3, A, 64'h0, ERR);
    reg_acc(1'b1, FAP_REG_CTRL, 32'h10);
    drain();
    compare(level_out, FAP_LVL2, "level kept");
    reg_acc(1'b0, FAP_REG_STATUS, 32'h30);
    reg_acc(1'b1, FAP_REG_STATUS, 32'h10);
    reg_acc(1'b0, FAP_REG_STATUS, 32'h20);
    reg_acc(1'b0, FAP_REG_ECC_ADDR, 32'h0);
    drain();
    wrap_up();
  end
endmodule // tb_top
